// File: hw/debug_pkg.sv
// Functional notes
// - One 16-bit software-writable breakpoint address compared against program counter.
// - Arm bit in flags register at 0FFh enables or disables breakpoint.
// - Armed match of program counter outside page 0FF00h-0FFFFh redirects fetch to vector 0FFF8h.
// - Redirect follows one cycle after the match; the matching fetch is still accepted.
// - Break entry into page 0FF00h-0FFFFh suspends timers and interrupts.
// - Leaving the debugger page after a break restores timers and interrupts.
// - Entering the page without a break leaves timers and interrupts running.
// - Debug boot strap low at power-on starts execution at 0FFFCh.
// - Four-byte two-way mailbox lets an outside computer talk to the monitor.
// - Strap pad comes up as input, becomes speaker drive once modulator enabled.
package debug_pkg;
   localparam logic [7:0] FLAGS_ADDR = 8'hFF;
   localparam logic [7:0] BRK_LO_ADDR = 8'hF0;
   localparam logic [7:0] BRK_HI_ADDR = 8'hF1;
   localparam logic [7:0] MOD_CTRL_ADDR = 8'hF2;
   localparam logic [7:0] MBOX_BASE_ADDR = 8'hF4;
   localparam logic [7:0] MBOX_STAT_ADDR = 8'hF8;
   localparam int TRAP_BIT = 7;
   localparam int MOD_EN_BIT = 0;
   localparam logic [7:0] FLAGS_RESET = 8'h00;
   localparam logic [15:0] BRK_RESET = 16'h0000;
   localparam logic [15:0] BREAK_VECTOR = 16'hFFF8;
   localparam logic [15:0] DEBUG_BOOT_VECTOR = 16'hFFFC;
   localparam logic [15:0] NORMAL_RESET_VECTOR = 16'h0000;
   localparam logic [7:0] DEBUG_PAGE = 8'hFF;
   localparam int MBOX_BYTES = 4;
   typedef enum logic [2:0] {
      ST_BOOT = 3'b001,
      ST_RUN = 3'b010,
      ST_HALTED = 3'b100
   } dbg_state_t;
endpackage

// File: hw/mailbox_bank.sv
`timescale 1ns/1ns
// Four-byte two-way mailbox between the monitor and an outside computer
module mailbox_bank
   import debug_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic [1:0] cpu_index,
   input wire logic cpu_write,
   input wire logic [7:0] cpu_wdata,
   input wire logic [1:0] ext_index,
   input wire logic ext_write,
   input wire logic [7:0] ext_wdata,
   output logic [31:0] to_ext,
   output logic [31:0] to_cpu,
   output logic to_ext_full,
   output logic to_cpu_full,
   input wire logic ext_ack,
   input wire logic cpu_ack
);
   logic [31:0] next_to_ext;
   logic [31:0] next_to_cpu;
   logic next_to_ext_full;
   logic next_to_cpu_full;

   // Byte writes per direction; byte 3 write marks the word full
   always_comb begin
      next_to_ext = to_ext;
      next_to_cpu = to_cpu;
      next_to_ext_full = to_ext_full;
      next_to_cpu_full = to_cpu_full;
      if (ext_ack) next_to_ext_full = 1'b0;
      if (cpu_ack) next_to_cpu_full = 1'b0;
      if (cpu_write) begin
         next_to_ext[cpu_index*8 +: 8] = cpu_wdata;
         if (cpu_index == 2'(MBOX_BYTES - 1)) next_to_ext_full = 1'b1;
      end
      if (ext_write) begin
         next_to_cpu[ext_index*8 +: 8] = ext_wdata;
         if (ext_index == 2'(MBOX_BYTES - 1)) next_to_cpu_full = 1'b1;
      end
   end

   // Registers
   always_ff @(posedge clk) begin
      if (reset) begin
         to_ext <= 32'h0000_0000;
         to_cpu <= 32'h0000_0000;
         to_ext_full <= 1'b0;
         to_cpu_full <= 1'b0;
      end else begin
         to_ext <= next_to_ext;
         to_cpu <= next_to_cpu;
         to_ext_full <= next_to_ext_full;
         to_cpu_full <= next_to_cpu_full;
      end
   end
endmodule

// File: hw/break_compare.sv
`timescale 1ns/1ns
// Combinational fetch-address match against the armed breakpoint
module break_compare
   import debug_pkg::*;
(
   input wire logic [15:0] fetch_addr,
   input wire logic fetch_valid,
   input wire logic [15:0] brk_addr,
   input wire logic armed,
   output logic hit
);
   // Only instruction fetches are compared, data accesses never are
   assign hit = fetch_valid & armed & (fetch_addr == brk_addr);
endmodule

// File: hw/code_breakpoint_debug_unit.sv
// Added by the designer: strobed register access.
`timescale 1ns/1ns
module code_breakpoint_debug_unit
   import debug_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [7:0] reg_rdata,
   input wire logic [15:0] fetch_addr,
   input wire logic fetch_valid,
   output logic redirect,
   output logic [15:0] redirect_addr,
   output logic suspend,
   input wire logic debug_boot_strap_in,
   output logic speaker_drive_b_out,
   output logic speaker_drive_b_oe,
   input wire logic speaker_pulse,
   input wire logic [1:0] ext_index,
   input wire logic ext_write,
   input wire logic [7:0] ext_wdata,
   input wire logic ext_ack,
   output logic [31:0] mbox_to_ext,
   output logic mbox_to_ext_full
);
   import debug_pkg::*;

   dbg_state_t state, next_state;
   logic [7:0] flags, next_flags;
   logic [15:0] brk_addr, next_brk_addr;
   logic mod_en, next_mod_en;
   logic in_break, next_in_break;
   logic [7:0] next_rdata;
   logic next_redirect;
   logic [15:0] next_redirect_addr;
   logic next_suspend;
   logic next_spk_out;
   logic next_spk_oe;
   logic hit;
   logic in_page;
   logic mb_cpu_write;
   logic mb_cpu_ack;
   logic [31:0] mb_to_cpu;
   logic mb_to_cpu_full;

   // Address falls inside the debugger page
   function automatic logic page_of(input logic [15:0] a);
      page_of = (a[15:8] == DEBUG_PAGE);
   endfunction

   // Mailbox byte address decode
   function automatic logic is_mbox(input logic [7:0] a);
      is_mbox = (a[7:2] == MBOX_BASE_ADDR[7:2]);
   endfunction

   break_compare u_cmp (
      .fetch_addr(fetch_addr),
      .fetch_valid(fetch_valid),
      .brk_addr(brk_addr),
      .armed(flags[TRAP_BIT]),
      .hit(hit)
   );

   assign mb_cpu_write = reg_write & is_mbox(reg_addr);
   assign mb_cpu_ack = reg_write & (reg_addr == MBOX_STAT_ADDR);

   mailbox_bank u_mbox (
      .clk(clk),
      .reset(reset),
      .cpu_index(reg_addr[1:0]),
      .cpu_write(mb_cpu_write),
      .cpu_wdata(reg_wdata),
      .ext_index(ext_index),
      .ext_write(ext_write),
      .ext_wdata(ext_wdata),
      .to_ext(mbox_to_ext),
      .to_cpu(mb_to_cpu),
      .to_ext_full(mbox_to_ext_full),
      .to_cpu_full(mb_to_cpu_full),
      .ext_ack(ext_ack),
      .cpu_ack(mb_cpu_ack)
   );

   assign in_page = page_of(fetch_addr);

   // Register writes
   always_comb begin
      next_flags = flags;
      next_brk_addr = brk_addr;
      next_mod_en = mod_en;
      if (reg_write) begin
         case (reg_addr)
            FLAGS_ADDR: next_flags = reg_wdata;
            BRK_LO_ADDR: next_brk_addr[7:0] = reg_wdata;
            BRK_HI_ADDR: next_brk_addr[15:8] = reg_wdata;
            MOD_CTRL_ADDR: next_mod_en = reg_wdata[MOD_EN_BIT];
            default: ;
         endcase
      end
   end

   // Register reads, data one cycle later; unmapped reads zero
   always_comb begin
      next_rdata = 8'h00;
      if (reg_read) begin
         if (is_mbox(reg_addr)) begin
            next_rdata = mb_to_cpu[reg_addr[1:0]*8 +: 8];
         end else begin
            case (reg_addr)
               FLAGS_ADDR: next_rdata = flags;
               BRK_LO_ADDR: next_rdata = brk_addr[7:0];
               BRK_HI_ADDR: next_rdata = brk_addr[15:8];
               MOD_CTRL_ADDR: next_rdata = {7'h00, mod_en};
               MBOX_STAT_ADDR: next_rdata = {5'h00, in_break, mbox_to_ext_full, mb_to_cpu_full};
               default: next_rdata = 8'h00;
            endcase
         end
      end
   end

   // Boot vector, break redirect and suspend tracking
   always_comb begin
      next_state = state;
      next_in_break = in_break;
      next_redirect = 1'b0;
      next_redirect_addr = redirect_addr;
      case (state)
         ST_BOOT: begin
            next_redirect = 1'b1;
            if (!debug_boot_strap_in) begin
               next_redirect_addr = DEBUG_BOOT_VECTOR;
            end else begin
               next_redirect_addr = NORMAL_RESET_VECTOR;
            end
            next_state = ST_RUN;
         end
         ST_RUN: begin
            if (hit && !in_page) begin
               // Redirect lands a cycle later; the matching fetch is accepted, the next one dropped
               next_redirect = 1'b1;
               next_redirect_addr = BREAK_VECTOR;
               next_in_break = 1'b1;
               next_state = ST_HALTED;
            end
         end
         ST_HALTED: begin
            if (fetch_valid && !in_page) begin
               next_in_break = 1'b0;
               next_state = ST_RUN;
               if (hit) begin
                  next_redirect = 1'b1;
                  next_redirect_addr = BREAK_VECTOR;
                  next_in_break = 1'b1;
                  next_state = ST_HALTED;
               end
            end
         end
         default: next_state = ST_RUN;
      endcase
      // Page entered by jump leaves in_break clear, so nothing is suspended
      next_suspend = next_in_break;
   end

   // Shared pad: input until the modulator is enabled
   always_comb begin
      next_spk_oe = mod_en;
      next_spk_out = mod_en & speaker_pulse;
   end

   // Software-visible register flip-flops
   always_ff @(posedge clk) begin
      if (reset) begin
         flags <= FLAGS_RESET;
         brk_addr <= BRK_RESET;
         mod_en <= 1'b0;
      end else begin
         flags <= next_flags;
         brk_addr <= next_brk_addr;
         mod_en <= next_mod_en;
      end
   end

   // Read data register, zero outside the answer cycle
   always_ff @(posedge clk) begin
      if (reset) begin
         reg_rdata <= 8'h00;
      end else begin
         reg_rdata <= next_rdata;
      end
   end

   // Boot, break and suspend flip-flops
   always_ff @(posedge clk) begin
      if (reset) begin
         state <= ST_BOOT;
         in_break <= 1'b0;
         redirect <= 1'b0;
         redirect_addr <= NORMAL_RESET_VECTOR;
         suspend <= 1'b0;
      end else begin
         state <= next_state;
         in_break <= next_in_break;
         redirect <= next_redirect;
         redirect_addr <= next_redirect_addr;
         suspend <= next_suspend;
      end
   end

   // Shared pad flip-flops, released to input by reset
   always_ff @(posedge clk) begin
      if (reset) begin
         speaker_drive_b_out <= 1'b0;
         speaker_drive_b_oe <= 1'b0;
      end else begin
         speaker_drive_b_out <= next_spk_out;
         speaker_drive_b_oe <= next_spk_oe;
      end
   end
endmodule

// File: tb/debug_unit_props.sv
`timescale 1ns/1ns
module debug_unit_props
   import debug_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   input wire logic [7:0] reg_rdata,
   input wire logic [15:0] fetch_addr,
   input wire logic fetch_valid,
   input wire logic redirect,
   input wire logic [15:0] redirect_addr,
   input wire logic suspend,
   input wire logic debug_boot_strap_in,
   input wire logic speaker_drive_b_oe
);
   logic [15:0] brk, next_brk;
   logic trap, next_trap, hit;
   // Shadow copy of breakpoint and arm bit
   always_comb begin
      next_brk = brk;
      next_trap = trap;
      if (reg_write && reg_addr == BRK_LO_ADDR) next_brk[7:0] = reg_wdata;
      if (reg_write && reg_addr == BRK_HI_ADDR) next_brk[15:8] = reg_wdata;
      if (reg_write && reg_addr == FLAGS_ADDR) next_trap = reg_wdata[TRAP_BIT];
   end
   always_ff @(posedge clk) begin
      brk <= reset ? BRK_RESET : next_brk;
      trap <= reset ? 1'b0 : next_trap;
   end
   assign hit = fetch_valid && trap && fetch_addr == brk && fetch_addr[15:8] != DEBUG_PAGE;
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   sequence s_vector;
      redirect && redirect_addr == BREAK_VECTOR;
   endsequence
   sequence s_leave;
      suspend && fetch_valid && fetch_addr[15:8] != DEBUG_PAGE && !hit;
   endsequence
   break_vector_a: assert property (hit |=> s_vector) else $error("no break redirect");
   break_suspend_a: assert property (hit |=> suspend) else $error("no suspend on break");
   leave_page_a: assert property (s_leave |=> !suspend) else $error("suspend kept");
   plain_entry_a: assert property (!suspend && !hit && !$past(reset) |=> !suspend) else $error("bad suspend");
   disarmed_a: assert property (!trap && !$past(reset) |=> !redirect) else $error("redirect disarmed");
   redirect_pulse_a: assert property (redirect |=> !redirect) else $error("redirect too long");
   boot_vector_a: assert property ($fell(reset) |=> redirect && redirect_addr ==
      ($past(debug_boot_strap_in) ? NORMAL_RESET_VECTOR : DEBUG_BOOT_VECTOR)) else $error("bad boot");
   brk_read_a: assert property ($past(reg_read) && $past(reg_addr) == BRK_HI_ADDR |-> reg_rdata == brk[15:8])
      else $error("bad brk read");
   pad_role_a: assert property (reg_write && reg_addr == MOD_CTRL_ADDR |=> ##1
      speaker_drive_b_oe == $past(reg_wdata[MOD_EN_BIT], 2)) else $error("bad pad role");
endmodule
bind code_breakpoint_debug_unit debug_unit_props u_props (.clk(clk), .reset(reset), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
   .fetch_addr(fetch_addr), .fetch_valid(fetch_valid), .redirect(redirect), .redirect_addr(redirect_addr),
   .suspend(suspend), .debug_boot_strap_in(debug_boot_strap_in), .speaker_drive_b_oe(speaker_drive_b_oe));

// File: tb/core_fetch_model.sv
`timescale 1ns/1ns
module core_fetch_model (
   input wire logic clk,
   input wire logic reset,
   input wire logic run,
   input wire logic jump,
   input wire logic [15:0] jump_addr,
   input wire logic redirect,
   input wire logic [15:0] redirect_addr,
   output logic [15:0] fetch_addr,
   output logic fetch_valid
);
   logic [15:0] pc, next_pc;
   // Redirected fetch is dropped; idle bus shows inverted address
   assign fetch_valid = run && !redirect && !jump;
   assign fetch_addr = fetch_valid ? pc : ~pc;
   // Program counter steps, jumps or takes the vector
   always_comb begin
      next_pc = pc;
      if (redirect) next_pc = redirect_addr;
      else if (jump) next_pc = jump_addr;
      else if (run) next_pc = pc + 16'h0001;
   end
   always_ff @(posedge clk) begin
      pc <= reset ? 16'h0000 : next_pc;
   end
endmodule

// File: tb/code_breakpoint_debug_unit_tb_top.sv
`timescale 1ns/1ns
module code_breakpoint_debug_unit_tb_top;
   import debug_pkg::*;
   logic clk = 0, reset = 1, reg_write = 0, reg_read = 0, fetch_valid, redirect, suspend, strap = 1;
   logic spk_out, spk_oe, spk_pulse = 0, ext_write = 0, ext_ack = 0, mfull, run = 0, jump = 0;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, ext_wdata = 8'h00;
   logic [15:0] fetch_addr, redirect_addr, jump_addr = 16'h0000, last_fetch = 16'h0000;
   logic [31:0] mbox, nred = 0, k;
   logic [1:0] ext_index = 2'h0;
   int mismatches = 0, cmp_count = 0;
   always #20 clk = ~clk;
   // Redirect count and last accepted fetch
   always @(posedge clk) begin
      if (redirect === 1'b1) nred <= nred + 1;
      if (fetch_valid === 1'b1) last_fetch <= fetch_addr;
   end
   code_breakpoint_debug_unit u_code_breakpoint_debug_unit (.clk(clk), .reset(reset), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
      .fetch_addr(fetch_addr), .fetch_valid(fetch_valid), .redirect(redirect), .redirect_addr(redirect_addr),
      .suspend(suspend), .debug_boot_strap_in(strap), .speaker_drive_b_out(spk_out), .speaker_drive_b_oe(spk_oe),
      .speaker_pulse(spk_pulse), .ext_index(ext_index), .ext_write(ext_write), .ext_wdata(ext_wdata),
      .ext_ack(ext_ack), .mbox_to_ext(mbox), .mbox_to_ext_full(mfull));
   core_fetch_model u_core_fetch_model (.clk(clk), .reset(reset), .run(run), .jump(jump), .jump_addr(jump_addr),
      .redirect(redirect), .redirect_addr(redirect_addr), .fetch_addr(fetch_addr), .fetch_valid(fetch_valid));
   task chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_write <= 1;
      @(posedge clk);
      reg_write <= 0;
   endtask
   task rdc(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk);
      reg_addr <= a;
      reg_read <= 1;
      @(posedge clk);
      reg_read <= 0;
      @(negedge clk);
      chk(reg_rdata, v);
   endtask
   task jmp(input logic [15:0] a);
      @(posedge clk);
      jump <= 1;
      jump_addr <= a;
      @(posedge clk);
      jump <= 0;
   endtask
   task rst(input logic s, input logic [15:0] v);
      @(posedge clk);
      run <= 0;
      strap <= s;
      reset <= 1;
      repeat (8) @(posedge clk);
      reset <= 0;
      @(posedge clk);
      @(negedge clk);
      chk(redirect, 1);
      chk(redirect_addr, v);
      @(posedge clk);
      run <= 1;
   endtask
   task t_regs;
      rdc(BRK_LO_ADDR, 8'h00);
      wr(BRK_LO_ADDR, 8'hA5);
      wr(BRK_HI_ADDR, 8'h5A);
      rdc(BRK_LO_ADDR, 8'hA5);
      rdc(BRK_HI_ADDR, 8'h5A);
      wr(FLAGS_ADDR, 8'h80);
      rdc(FLAGS_ADDR, 8'h80);
      wr(8'h30, 8'hFF);
      rdc(8'h30, 8'h00);
   endtask
   task t_break;
      int n;
      wr(BRK_LO_ADDR, 8'h10);
      wr(BRK_HI_ADDR, 8'h02);
      wr(FLAGS_ADDR, 8'h80);
      jmp(16'h020C);
      n = 0;
      while (redirect !== 1'b1 && n < 20) begin
         @(negedge clk);
         n++;
      end
      chk(redirect_addr, 16'hFFF8);
      chk(last_fetch, 16'h0210);
      repeat (3) @(negedge clk);
      chk(suspend, 1);
      jmp(16'h0100);
      repeat (2) @(negedge clk);
      chk(suspend, 0);
      wr(FLAGS_ADDR, 8'h00);
      k = nred;
      jmp(16'h020C);
      repeat (8) @(negedge clk);
      chk(nred, k);
      jmp(16'hFFF0);
      repeat (5) @(negedge clk);
      chk(suspend, 0);
   endtask
   task t_spk;
      chk(spk_oe, 0);
      @(posedge clk);
      spk_pulse <= 1;
      wr(MOD_CTRL_ADDR, 8'h01);
      repeat (2) @(negedge clk);
      chk({spk_oe, spk_out}, 2'b11);
      wr(MOD_CTRL_ADDR, 8'h00);
      repeat (2) @(negedge clk);
      chk(spk_oe, 0);
   endtask
   task t_mbox;
      for (int i = 0; i < MBOX_BYTES; i++) wr(MBOX_BASE_ADDR + 8'(i), 8'h11 * 8'(i + 1));
      @(negedge clk);
      chk(mbox, 32'h44332211);
      chk(mfull, 1);
      @(posedge clk);
      ext_ack <= 1;
      @(posedge clk);
      ext_ack <= 0;
      @(negedge clk);
      chk(mfull, 0);
      for (int i = 0; i < MBOX_BYTES; i++) begin
         @(posedge clk);
         ext_index <= 2'(i);
         ext_wdata <= 8'hA0 + 8'(i);
         ext_write <= 1;
      end
      @(posedge clk);
      ext_write <= 0;
      rdc(8'hF7, 8'hA3);
      rdc(MBOX_STAT_ADDR, 8'h01);
      wr(MBOX_STAT_ADDR, 8'h00);
      rdc(MBOX_STAT_ADDR, 8'h00);
   endtask
   task summarize;
      $display("mismatches=%0d cmp_count=%0d", mismatches, cmp_count);
      if (mismatches == 0 && cmp_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // Main sequence
   initial begin
      rst(1'b1, NORMAL_RESET_VECTOR);
      t_regs;
      t_break;
      t_spk;
      t_mbox;
      rst(1'b0, 16'hFFFC);
      rdc(FLAGS_ADDR, 8'h00);
      summarize;
   end
   // Hang guard
   initial begin
      #100000;
      mismatches++;
      summarize;
   end
endmodule
